// file: hdl/sdram_col_burst.sv
// Behaviour
// - hold column command for posted delay
// - read latency is posted delay plus column latency
// - write latency is read latency minus one
// - only bursts of four and eight, no stop
// - burst type bit picks ordering at mode load
// - sequential wraps low two bits, nibble order
// - interleaved column is start xor beat index
// - decode read command from strobes
// - decode write command from strobes
// - first read word at read latency
// - strobe low one clock before read data
// - read data edge aligned with strobe edges
// - gapless reads every burst half-length clocks
// - interrupting read two clocks later cuts at four
// - spacing follows programmed burst length
// - capture four or eight words, drop rest
// - gapless writes every burst half-length clocks

`include "sdram_col_cfg.svh"

module sdram_col_burst
  import sdram_col_pkg::*;
(
  // core side
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  // command pins, link clock
  input  wire logic                 i_link_clk,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_ras_n,
  input  wire logic                 i_cas_n,
  input  wire logic                 i_we_n,
  input  wire logic [1:0]           i_ba,
  input  wire logic [`ADDR_W-1:0]   i_addr,
  // data pins, one word per strobe edge
  input  wire sdram_col_pkg::word_t i_dq_rise,
  input  wire sdram_col_pkg::word_t i_dq_fall,
  input  wire logic                 i_dqs,
  output logic [`DQ_W-1:0]          o_dq_rise,
  output logic [`DQ_W-1:0]          o_dq_fall,
  output logic                      o_dq_oe,
  output logic                      o_dqs,
  output logic                      o_dqs_oe,
  // status on core clock
  output logic                      o_read_busy,
  output logic                      o_write_busy,
  output logic                      o_write_done
);
  import sdram_col_pkg::*;

  // ===================================================================
  // reset brought into the link domain
  logic  rst_m_n;
  logic  rst_s_n;

  always_ff @(posedge i_link_clk)
  begin
    rst_m_n <= i_rst_n;
    rst_s_n <= rst_m_n;
  end

  // ===================================================================
  // link domain
  link_s      q;
  link_s      n;
  logic       rd_cmd;
  logic       wr_cmd;
  logic       mode_cmd;
  logic [3:0] read_latency;
  logic [3:0] write_latency;
  logic       rd_start;
  logic       rd_pre;
  logic       wr_start;
  logic       rd_last;
  logic       wr_last;
  col_t       rd_addr;

  // latencies and taps come from registered mode bits only
  always_comb
  begin
    rd_cmd   = !i_cs_n && i_ras_n && !i_cas_n && i_we_n;
    wr_cmd   = !i_cs_n && i_ras_n && !i_cas_n && !i_we_n;
    mode_cmd = !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n;
    read_latency  = 4'({1'b0, q.posted_delay}
                    + {1'b0, q.column_latency});
    write_latency = 4'(read_latency - 4'h1);
    // tap k holds a command k+1 edges old; the posted delay is the
    // front part of this line, so execution waits on it
    rd_start = q.p_rd[read_latency - 4'h1];
    rd_pre   = q.p_rd[read_latency - 4'h2];
    wr_start = q.p_wr[write_latency - 4'h1];
    rd_last  = q.rd_beat == (q.rd_bl8 ? 2'h3 : 2'h1);
    wr_last  = q.wr_beat == (q.wr_bl8 ? 2'h3 : 2'h1);
    rd_addr  = burst_col(q.rd_col, {q.rd_beat, 1'b0}, q.rd_bl8, q.rd_il);
  end

  always_comb
  begin
    n = q;
    n.p_rd  = {q.p_rd[`PIPE_D-2:0], rd_cmd};
    n.p_wr  = {q.p_wr[`PIPE_D-2:0], wr_cmd};
    n.p_col = {q.p_col[`PIPE_D-2:0], i_addr[`COL_W-1:0]};

    // mode loads; unsupported burst length codes are not taken
    if (mode_cmd && i_ba == `BA_MR)
    begin
      if (i_addr[`MR_BL_LSB +: 3] == `BL8_CODE
          || i_addr[`MR_BL_LSB +: 3] == `BL4_CODE)
      begin
        n.bl8 = i_addr[`MR_BL_LSB +: 3] == `BL8_CODE;
      end
      n.interleave     = i_addr[`MR_BT_BIT];
      n.column_latency = i_addr[`MR_CL_LSB +: 3];
    end
    if (mode_cmd && i_ba == `BA_EMR1)
    begin
      n.posted_delay = i_addr[`EMR_AL_LSB +: 3];
    end

    // read engine
    case (q.rd_st)
      RD_IDLE:
      begin
        n.rd_st = rd_pre ? RD_PRE : RD_IDLE;
      end
      RD_PRE:
      begin
        n.rd_st = rd_start ? RD_DATA : RD_IDLE;
      end
      RD_DATA:
      begin
        if (rd_start)
        begin
          n.rd_st = RD_DATA;
        end
        else if (!rd_last)
        begin
          n.rd_beat = 2'(q.rd_beat + 2'h1);
        end
        else
        begin
          n.rd_st = rd_pre ? RD_PRE : RD_POST;
        end
      end
      RD_POST:
      begin
        n.rd_st = rd_pre ? RD_PRE : RD_IDLE;
      end
      default:
      begin
        n.rd_st = RD_IDLE;
      end
    endcase
    // a new start cuts the running burst at whatever beat it arrives;
    // length is the programmed one, never the cut one
    if (rd_start)
    begin
      n.rd_st   = RD_DATA;
      n.rd_beat = 2'h0;
      n.rd_col  = q.p_col[read_latency - 4'h1];
      n.rd_bl8  = q.bl8;
      n.rd_il   = q.interleave;
    end

    // write engine; words past the burst end are never stored
    if (q.wr_act)
    begin
      if (i_dqs)
      begin
        n.mem[burst_col(q.wr_col, {q.wr_beat, 1'b0}, q.wr_bl8,
                        q.wr_il)] = i_dq_rise;
        n.mem[burst_col(q.wr_col, {q.wr_beat, 1'b1}, q.wr_bl8,
                        q.wr_il)] = i_dq_fall;
      end
      if (wr_last)
      begin
        n.wr_act   = 1'b0;
        n.done_tgl = !q.done_tgl;
      end
      else
      begin
        n.wr_beat = 2'(q.wr_beat + 2'h1);
      end
    end
    if (wr_start)
    begin
      n.wr_act  = 1'b1;
      n.wr_beat = 2'h0;
      n.wr_col  = q.p_col[write_latency - 4'h1];
      n.wr_bl8  = q.bl8;
      n.wr_il   = q.interleave;
    end

    // pins follow the next state so they leave flip-flops directly
    n.dq_oe   = n.rd_st == RD_DATA;
    n.dqs_oe  = n.rd_st != RD_IDLE;
    n.dqs     = n.rd_st == RD_DATA;
    n.dq_rise = q.mem[burst_col(n.rd_col, {n.rd_beat, 1'b0}, n.rd_bl8,
                                n.rd_il)];
    n.dq_fall = q.mem[burst_col(n.rd_col, {n.rd_beat, 1'b1}, n.rd_bl8,
                                n.rd_il)];
    n.rd_busy = n.rd_st != RD_IDLE;
    n.wr_busy = n.wr_act;

    if (!rst_s_n)
    begin
      n = '0;
      n.column_latency = `CL_RST;
      n.posted_delay   = `AL_RST;
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    q <= n;
  end

  // ===================================================================
  // core domain: busy levels and done toggle cross through two flops
  // levels only: a busy shorter than one core clock could be missed
  core_s c;
  core_s c_n;

  always_comb
  begin
    c_n = c;
    c_n.rdb_m      = q.rd_busy;
    c_n.rdb_s      = c.rdb_m;
    c_n.wrb_m      = q.wr_busy;
    c_n.wrb_s      = c.wrb_m;
    c_n.tgl_m      = q.done_tgl;
    c_n.tgl_s      = c.tgl_m;
    c_n.tgl_p      = c.tgl_s;
    c_n.read_busy  = c.rdb_s;
    c_n.write_busy = c.wrb_s;
    c_n.write_done = c.tgl_s ^ c.tgl_p;
    if (!i_rst_n)
    begin
      c_n = '0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    c <= c_n;
  end

  assign o_dq_rise    = q.dq_rise;
  assign o_dq_fall    = q.dq_fall;
  assign o_dq_oe      = q.dq_oe;
  assign o_dqs        = q.dqs;
  assign o_dqs_oe     = q.dqs_oe;
  assign o_read_busy  = c.read_busy;
  assign o_write_busy = c.write_busy;
  assign o_write_done = c.write_done;

  // ===================================================================
  // checks on the link clock
  sequence s_b4_alone;
    rd_start && !q.bl8 ##1 !rd_start [*2];
  endsequence

  sequence s_eight_words;
    q.dq_oe [*4];
  endsequence

  a_read_start: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) rd_start |=> q.dq_oe && q.rd_beat == 2'h0)
    else $error("read data not out at read latency");
  a_read_pre: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) rd_pre && q.rd_st != RD_DATA
    |=> q.dqs_oe && !q.dqs && !q.dq_oe)
    else $error("missing read preamble");
  a_strobe_align: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.dq_oe |-> q.dqs && q.dqs_oe)
    else $error("read data without strobe");
  a_write_lat: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.p_wr[write_latency - 4'h1]
    |=> q.wr_act && q.wr_beat == 2'h0)
    else $error("write capture not at write latency");
  a_eight_len: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) rd_start && q.bl8 |=> s_eight_words)
    else $error("burst of eight too short");
  a_four_stop: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) s_b4_alone |=> !q.dq_oe)
    else $error("burst of four runs long");
  a_pins_idle: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.rd_st == RD_IDLE |-> !q.dq_oe && !q.dqs_oe)
    else $error("pins driven while idle");
  a_il_order: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.dq_oe && q.rd_il && q.rd_bl8
    |-> rd_addr[2:0] == (q.rd_col[2:0] ^ {q.rd_beat, 1'b0}))
    else $error("interleaved order wrong");
  a_seq_order: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.dq_oe && !q.rd_il && q.rd_bl8
    |-> rd_addr[2] == (q.rd_col[2] ^ q.rd_beat[1])
     && rd_addr[1:0] == 2'(q.rd_col[1:0] + {q.rd_beat[0], 1'b0}))
    else $error("sequential order wrong");
  a_cut_four: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.rd_st == RD_DATA && q.rd_beat == 2'h1 && rd_start
    |=> q.dq_oe && q.rd_beat == 2'h0)
    else $error("interrupting read not taken");
  a_write_drop: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) !q.wr_act |=> $stable(q.mem))
    else $error("data stored outside write burst");
  a_cmd_decode: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) !i_cs_n && i_ras_n && !i_cas_n
    |=> q.p_rd[0] == !q.p_wr[0])
    else $error("column command misdecoded");

  sequence s_post_amble;
    q.dqs_oe && !q.dqs && !q.dq_oe;
  endsequence

  a_post_amble: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.rd_st == RD_DATA && rd_last && !rd_start
    |=> s_post_amble)
    else $error("missing read postamble");
  a_gapless_read: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.rd_st == RD_DATA && rd_last && rd_start
    |=> q.dq_oe && q.dqs && q.rd_beat == 2'h0)
    else $error("gap between back to back reads");
  a_write_end: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.wr_act && wr_last && !wr_start
    |=> !q.wr_act && q.done_tgl != $past(q.done_tgl))
    else $error("write burst not closed after last pair");
  a_write_gapless: assert property (@(posedge i_link_clk) disable iff
    (!rst_s_n) q.wr_act && wr_last && wr_start
    |=> q.wr_act && q.wr_beat == 2'h0)
    else $error("gap between back to back writes");

endmodule : sdram_col_burst

// file: common/sdram_col_cfg.svh
`ifndef SDRAM_COL_CFG_SVH
`define SDRAM_COL_CFG_SVH

// =====================================================================
// widths
`define DQ_W        16
`define COL_W       4
`define ADDR_W      7
`define PIPE_D      16

// =====================================================================
// mode register and extended mode register one field positions
`define MR_BL_LSB   0
`define MR_BT_BIT   3
`define MR_CL_LSB   4
`define EMR_AL_LSB  3
`define BL4_CODE    3'h2
`define BL8_CODE    3'h3
`define BA_MR       2'h0
`define BA_EMR1     2'h1

// =====================================================================
// reset values
`define CL_RST      3'h3
`define AL_RST      3'h0

`endif

// file: common/sdram_col_pkg.sv
`include "sdram_col_cfg.svh"

package sdram_col_pkg;

  // ===================================================================
  // read engine states, gray along idle-pre-data-post
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_PRE  = 2'h1,
    RD_DATA = 2'h3,
    RD_POST = 2'h2
  } rd_state_e;

  typedef logic [`COL_W-1:0] col_t;
  typedef logic [`DQ_W-1:0]  word_t;

  // ===================================================================
  // link domain state
  typedef struct packed {
    logic                                bl8;
    logic                                interleave;
    logic [2:0]                          column_latency;
    logic [2:0]                          posted_delay;
    logic [`PIPE_D-1:0]                  p_rd;
    logic [`PIPE_D-1:0]                  p_wr;
    logic [`PIPE_D-1:0][`COL_W-1:0]      p_col;
    rd_state_e                           rd_st;
    logic [1:0]                          rd_beat;
    logic                                rd_bl8;
    logic                                rd_il;
    col_t                                rd_col;
    logic                                wr_act;
    logic [1:0]                          wr_beat;
    logic                                wr_bl8;
    logic                                wr_il;
    col_t                                wr_col;
    logic [(1<<`COL_W)-1:0][`DQ_W-1:0]   mem;
    word_t                               dq_rise;
    word_t                               dq_fall;
    logic                                dq_oe;
    logic                                dqs;
    logic                                dqs_oe;
    logic                                rd_busy;
    logic                                wr_busy;
    logic                                done_tgl;
  } link_s;

  // ===================================================================
  // core domain state
  typedef struct packed {
    logic rdb_m;
    logic rdb_s;
    logic wrb_m;
    logic wrb_s;
    logic tgl_m;
    logic tgl_s;
    logic tgl_p;
    logic read_busy;
    logic write_busy;
    logic write_done;
  } core_s;

  // ===================================================================
  // column of beat i within the burst segment
  function automatic col_t burst_col(
    input col_t       start,
    input logic [2:0] i,
    input logic       bl8,
    input logic       il
  );
    logic [2:0] lo;
    lo = start[2:0];
    if (il)
    begin
      lo = lo ^ (bl8 ? i : {1'b0, i[1:0]});
    end
    else
    begin
      lo = {lo[2] ^ (bl8 & i[2]), 2'(lo[1:0] + i[1:0])};
    end
    return {start[`COL_W-1:3], lo};
  endfunction : burst_col

endpackage : sdram_col_pkg

// file: sim/sdram_ctl_model.sv
`include "sdram_col_cfg.svh"

// =====================================================================
// controller side of the command and data pins
module sdram_ctl_model
(
  // link clock
  input  wire logic                 i_link_clk,
  // command pins
  output logic [3:0]                o_cmd_n,
  output logic [1:0]                o_ba,
  output logic [`ADDR_W-1:0]        o_addr,
  // write data, one pair per clock
  output sdram_col_pkg::word_t      o_dq_rise,
  output sdram_col_pkg::word_t      o_dq_fall,
  output logic                      o_dqs
);
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_col_pkg::*;

  initial
  begin
    o_cmd_n   = 4'hf;
    o_ba      = 2'h0;
    o_addr    = '0;
    o_dq_rise = '0;
    o_dq_fall = '0;
    o_dqs     = 1'b0;
  end

  // one clock per command; the encoding has no stop code at all
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba,
                     input logic [`ADDR_W-1:0] a);
    o_cmd_n = c;
    o_ba    = ba;
    o_addr  = a;
    @(negedge i_link_clk);
    o_cmd_n = 4'hf;
    o_addr  = ~a;
  endtask : cmd

  // pairs start after edge wl; released lines show inverted data
  task automatic send(input int wl, input word_t q[$]);
    int i;
    repeat (wl + 1) @(negedge i_link_clk);
    for (i = 0; i < q.size(); i += 2)
    begin
      o_dqs     = 1'b1;
      o_dq_rise = q[i];
      o_dq_fall = q[i+1];
      @(negedge i_link_clk);
    end
    o_dqs     = 1'b0;
    o_dq_rise = ~o_dq_rise;
    o_dq_fall = ~o_dq_fall;
  endtask : send

endmodule : sdram_ctl_model

// file: sim/sdram_column_burst_access_test.sv
`include "sdram_col_cfg.svh"

module sdram_column_burst_access_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_col_pkg::*;

  // ===================================================================
  // signals and state
  logic         i_core_clk;
  logic         i_link_clk;
  logic         i_rst_n;
  logic [3:0]   cmd_n;
  logic [1:0]   ba;
  logic [6:0]   addr;
  word_t        dq_rise;
  word_t        dq_fall;
  logic         dqs;
  word_t        o_dq_rise;
  word_t        o_dq_fall;
  logic         o_dq_oe;
  logic         o_dqs;
  logic         o_dqs_oe;
  logic         o_read_busy;
  logic         o_write_busy;
  logic         o_write_done;
  int           errors = 0;
  int           checked = 0;
  int           cycles = 0;
  int           dones = 0;
  logic         rd_seen = 1'b0;
  logic         wr_seen = 1'b0;
  logic         bl8 = 1'b0;
  logic         il = 1'b0;
  int           rl = 3;
  word_t        nxt = 16'hc000;
  word_t        mem [16];

  sdram_ctl_model u_ctl (.i_link_clk(i_link_clk), .o_cmd_n(cmd_n),
    .o_ba(ba), .o_addr(addr), .o_dq_rise(dq_rise), .o_dq_fall(dq_fall),
    .o_dqs(dqs));

  sdram_col_burst u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_link_clk(i_link_clk), .i_cs_n(cmd_n[3]), .i_ras_n(cmd_n[2]),
    .i_cas_n(cmd_n[1]), .i_we_n(cmd_n[0]), .i_ba(ba), .i_addr(addr),
    .i_dq_rise(dq_rise), .i_dq_fall(dq_fall), .i_dqs(dqs),
    .o_dq_rise(o_dq_rise), .o_dq_fall(o_dq_fall), .o_dq_oe(o_dq_oe),
    .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe), .o_read_busy(o_read_busy),
    .o_write_busy(o_write_busy), .o_write_done(o_write_done));

  // ===================================================================
  // clocks, offset so no link edge meets a core edge
  always #5 i_core_clk = ~i_core_clk;

  initial
  begin
    i_link_clk = 1'b0;
    #3.3;
    forever #32 i_link_clk = ~i_link_clk;
  end

  always @(negedge i_core_clk)
  begin
    cycles++;
    if (o_write_done === 1'b1) dones++;
    if (o_read_busy === 1'b1) rd_seen = 1'b1;
    if (o_write_busy === 1'b1) wr_seen = 1'b1;
    if (cycles == 8000)
    begin
      errors++;
      stop_test();
    end
  end

  // ===================================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic col_t ord(input col_t s, input int i);
    logic [2:0] k;
    k = 3'(i);
    if (!bl8) k[2] = 1'b0;
    if (il) return {s[3], s[2:0] ^ k};
    return {s[3], s[2] ^ k[2], 2'(s[1:0] + k[1:0])};
  endfunction : ord

  task automatic mode(input logic [2:0] code, input logic il_v,
                      input int cl, input int al);
    u_ctl.cmd(4'h0, 2'h0, {3'(cl), il_v, code});
    @(negedge i_link_clk);
    u_ctl.cmd(4'h0, 2'h1, {1'b0, 3'(al), 3'h0});
    repeat (2) @(negedge i_link_clk);
    if (code[2:1] == 2'b01) bl8 = code[0];
    il = il_v;
    rl = cl + al;
  endtask : mode

  task automatic rd_chk(input word_t q[$]);
    int i;
    repeat (rl) @(negedge i_link_clk);
    check({13'h0, o_dqs_oe, o_dqs, o_dq_oe}, 16'h4);
    for (i = 0; i < q.size(); i += 2)
    begin
      @(negedge i_link_clk);
      check({13'h0, o_dqs_oe, o_dqs, o_dq_oe}, 16'h7);
      check(o_dq_rise, q[i]);
      check(o_dq_fall, q[i+1]);
    end
    @(negedge i_link_clk);
    check({13'h0, o_dqs_oe, o_dqs, o_dq_oe}, 16'h4);
    @(negedge i_link_clk);
    check({13'h0, o_dqs_oe, o_dqs, o_dq_oe}, 16'h0);
  endtask : rd_chk

  // first burst gives n1 words, a second command gap clocks later
  task automatic burst(input logic wr, input col_t a, input col_t b,
                       input int gap, input int n1, input int np);
    word_t q[$];
    col_t  c;
    int    j;
    for (j = 0; j < n1 + (gap > 0 ? (bl8 ? 8 : 4) : 0); j++)
    begin
      c = (j < n1) ? ord(a, j) : ord(b, j - n1);
      if (wr) mem[c] = nxt++;
      q.push_back(mem[c]);
    end
    while (wr && q.size() < 2 * np) q.push_back(nxt++);
    fork
      begin
        u_ctl.cmd(wr ? 4'h4 : 4'h5, 2'h0, 7'(a));
        if (gap > 0)
        begin
          repeat (gap - 1) @(negedge i_link_clk);
          u_ctl.cmd(wr ? 4'h4 : 4'h5, 2'h0, 7'(b));
        end
      end
      begin
        @(posedge i_link_clk);
        if (wr) u_ctl.send(rl - 1, q);
        else rd_chk(q);
      end
    join
    repeat (4) @(negedge i_link_clk);
  endtask : burst

  // ===================================================================
  // scenarios
  task automatic t_basic();
    int d0;
    d0 = dones;
    mode(3'h2, 1'b0, 3, 0);
    burst(1'b1, 4'h0, 4'h0, 0, 4, 2);
    repeat (12) @(negedge i_core_clk);
    check(16'(dones - d0), 16'h1);
    check({14'h0, wr_seen, rd_seen}, 16'h2);
    check({14'h0, o_write_busy, o_read_busy}, 16'h0);
    // back onto a link falling edge so the next command is sampled
    @(negedge i_link_clk);
    burst(1'b0, 4'h1, 4'h0, 0, 4, 0);
    check({15'h0, rd_seen}, 16'h1);
    $display("basic done");
  endtask : t_basic

  task automatic t_posted();
    mode(3'h3, 1'b1, 3, 2);
    burst(1'b1, 4'h8, 4'h0, 0, 8, 4);
    burst(1'b0, 4'hd, 4'h0, 0, 8, 0);
    $display("posted done");
  endtask : t_posted

  task automatic t_seq8();
    mode(3'h3, 1'b0, 3, 0);
    burst(1'b0, 4'he, 4'h0, 0, 8, 0);
    $display("seq8 done");
  endtask : t_seq8

  task automatic t_gapless();
    mode(3'h2, 1'b0, 3, 0);
    burst(1'b1, 4'h4, 4'h0, 2, 4, 4);
    burst(1'b0, 4'h0, 4'h5, 2, 4, 0);
    $display("gapless done");
  endtask : t_gapless

  task automatic t_interrupt();
    mode(3'h3, 1'b0, 3, 0);
    mode(3'h1, 1'b0, 3, 0);
    burst(1'b0, 4'h2, 4'h9, 2, 4, 0);
    $display("interrupt done");
  endtask : t_interrupt

  task automatic t_extra();
    mode(3'h2, 1'b0, 3, 0);
    burst(1'b1, 4'h4, 4'h0, 0, 4, 3);
    mode(3'h3, 1'b0, 3, 0);
    burst(1'b0, 4'h0, 4'h0, 0, 8, 0);
    $display("extra done");
  endtask : t_extra

  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // ===================================================================
  // main sequence; link side needs several link edges of reset
  initial
  begin
    i_core_clk = 1'b0;
    i_rst_n    = 1'b0;
    repeat (10) @(negedge i_core_clk);
    repeat (4) @(negedge i_link_clk);
    @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (5) @(negedge i_link_clk);
    t_basic();
    t_posted();
    t_seq8();
    t_gapless();
    t_interrupt();
    t_extra();
    stop_test();
  end

endmodule : sdram_column_burst_access_test
